/* dv/decoder_asserts.sv */
`timescale 1ns/1ns
`default_nettype none

// ----
// decode checker on the decoder ports
// ----
module decoder_asserts (
    input wire logic                                 clk,
    input wire logic                                 sys_rst,
    input wire bridge_decode_pkg::cfg_access_type    cfg_req,
    input wire logic [31:0]                          cfg_rdata,
    input wire logic                                 cfg_rd_valid,
    input wire bridge_decode_pkg::enables_type       enables,
    input wire bridge_decode_pkg::txn_req_type       txn,
    input wire logic                                 other_claim,
    input wire bridge_decode_pkg::decode_result_type dec,
    input wire logic                                 io_window_off,
    input wire logic                                 mmio_window_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // request and result qualifiers
    wire logic pri  = txn.valid && txn.side == bridge_decode_pkg::SIDE_PRIMARY;
    wire logic sec  = txn.valid && txn.side == bridge_decode_pkg::SIDE_SECONDARY;
    wire logic io   = txn.kind == bridge_decode_pkg::KIND_IO;
    wire logic ign  = dec.action == bridge_decode_pkg::ACT_IGNORE;
    wire logic down = dec.action == bridge_decode_pkg::ACT_DOWNSTREAM;
    wire logic up   = dec.action == bridge_decode_pkg::ACT_UPSTREAM;
    wire logic top  = enables.isa && txn.addr[31:16] == 16'h0000 && txn.addr[9:8] != 2'h0;

    // result lands one cycle after the request, fields copied through
    sequence s_req;
        txn.valid;
    endsequence
    sequence s_copy;
        dec.valid && dec.addr == $past(txn.addr) && dec.side == $past(txn.side)
            && dec.kind == $past(txn.kind);
    endsequence

    a_addr_unmodified: assert property (s_req |=> s_copy)
        else $error("result is not a copy of the request");
    a_rd_answer: assert property (cfg_req.rd |=> cfg_rd_valid)
        else $error("config read not answered next cycle");
    a_io_enable_gate: assert property (pri && io && !enables.io_space |=> ign)
        else $error("primary io decoded with io enable clear");
    a_master_gate: assert property (sec && !enables.bus_master |=> ign)
        else $error("secondary traffic decoded with master enable clear");
    a_io_off_route: assert property (txn.valid && io && io_window_off |=> !down)
        else $error("io sent down while io window off");
    a_isa_top_held: assert property (pri && io && top |=> !down)
        else $error("isa top 768 bytes sent down");
    a_isa_top_up: assert property (sec && io && top && enables.bus_master |=> up)
        else $error("isa top 768 bytes not sent up");
    a_mem_enable_gate: assert property (pri && !io && !enables.mem_space |=> ign)
        else $error("memory decoded with memory enable clear");
    a_read_policy: assert property (pri && !io |=>
        dec.prefetch == (down && ($past(txn.cmd) == 4'hc || $past(txn.cmd) == 4'he))
            && dec.single == (down && $past(txn.cmd) == 4'h6))
        else $error("read policy flags wrong");
    a_mmio_off_ignore: assert property (pri && !io && mmio_window_off |=> ign)
        else $error("memory sent down while mmio window off");
    a_claim_blocks: assert property (sec && !io && other_claim |=> !up)
        else $error("claimed secondary memory sent up");
    a_primary_not_up: assert property (pri |=> !up)
        else $error("primary request sent up");
endmodule

bind bridge_io_mmio_window_decoder decoder_asserts decoder_asserts_i (
    .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .enables(enables), .txn(txn), .other_claim(other_claim),
    .dec(dec), .io_window_off(io_window_off), .mmio_window_off(mmio_window_off)
);

`default_nettype wire

/* dv/pci_initiator_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----
// initiator on either bus, one address phase per call
// ----
module pci_initiator_model (
    input  wire logic                                 clk,
    input  wire bridge_decode_pkg::decode_result_type dec,
    output bridge_decode_pkg::txn_req_type            txn
);
    initial txn = '0;

    // idle bus shows the inverted address so a stale value never decodes right
    task automatic issue(input logic s, input logic k, input logic [3:0] c, input logic [31:0] a,
                         output bridge_decode_pkg::decode_result_type r);
        @(posedge clk);
        #1 txn = {1'b1, s, k, c, a};
        @(posedge clk);
        #1 r = dec;
        txn = {1'b0, s, k, c, ~a};
    endtask
endmodule

`default_nettype wire

/* dv/tb_bridge_io_mmio_window_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bridge_decode_cfg.svh"

module tb_bridge_io_mmio_window_decoder;
    logic                                 clk;
    logic                                 sys_rst;
    bridge_decode_pkg::cfg_access_type    cfg_req;
    logic [31:0]                          cfg_rdata;
    logic                                 cfg_rd_valid;
    bridge_decode_pkg::enables_type       en;
    bridge_decode_pkg::txn_req_type       txn;
    logic                                 oc;
    bridge_decode_pkg::decode_result_type dec;
    logic                                 io_off;
    logic                                 mmio_off;
    int                                   err_total;
    int                                   num_checks;
    // expected {prefetch, single, action}
    localparam logic [3:0] ig = 4'h0, dn = 4'h1, up = 4'h3, dn_sg = 4'h5, dn_pf = 4'h9;
    localparam logic pr = 1'b0, se = 1'b1, io = 1'b0, me = 1'b1;

    bridge_io_mmio_window_decoder bridge_io_mmio_window_decoder_i (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid), .enables(en), .txn(txn), .other_claim(oc), .dec(dec),
        .io_window_off(io_off), .mmio_window_off(mmio_off));
    pci_initiator_model pci_initiator_model_i (.clk(clk), .dec(dec), .txn(txn));

    always #20 clk = ~clk;

    // ----
    // shared helpers
    // ----
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1 cfg_req = {1'b0, 1'b1, a, be, d};
        @(posedge clk);
        #1 cfg_req.wr = 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        #1 cfg_req = {1'b1, 1'b0, a, 4'h0, 32'h0};
        @(posedge clk);
        #1 cfg_req.rd = 1'b0;
        chk({31'h0, cfg_rd_valid}, 32'h1);
        chk(cfg_rdata, exp);
    endtask
    // enables as {io, mem, master, isa}, changed only with no transfer in flight
    task automatic en_set(input logic [3:0] v);
        @(posedge clk);
        #1 en = v;
    endtask
    task automatic tx(input logic s, input logic k, input logic [3:0] c, input logic [31:0] a,
                      input logic [3:0] e);
        bridge_decode_pkg::decode_result_type r;
        pci_initiator_model_i.issue(s, k, c, a, r);
        chk({r.valid, r.side, r.kind, r.prefetch, r.single, r.action}, {1'b1, s, k, e});
        chk(r.addr, a);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        cfg_rd(`CFG_OFF_IO_BASE_LOW, 32'h0000_0101);
        cfg_rd(`CFG_OFF_MMIO_BASE, 32'h0000_0000);
        cfg_rd(`CFG_OFF_IO_BASE_HIGH, 32'h0000_0000);
        chk({30'h0, io_off, mmio_off}, 32'h0);
        en_set(4'he);
        tx(pr, io, 4'h2, 32'h0000_0fff, dn);
        tx(pr, io, 4'h2, 32'h0000_1000, ig);
        tx(pr, me, 4'h7, 32'h000f_fffc, dn);
        tx(pr, me, 4'h7, 32'h0010_0000, ig);
    endtask
    task automatic t_io();
        en_set(4'h0);
        cfg_wr(`CFG_OFF_IO_BASE_HIGH, 4'hf, 32'h0001_0001);
        cfg_wr(`CFG_OFF_IO_BASE_LOW, 4'h3, 32'hffff_5f2f);
        cfg_rd(`CFG_OFF_IO_BASE_LOW, 32'h0000_5121);
        cfg_rd(`CFG_OFF_IO_BASE_HIGH, 32'h0001_0001);
        en_set(4'ha);
        tx(pr, io, 4'h2, 32'h0001_2000, dn);
        tx(pr, io, 4'h3, 32'h0001_5fff, dn);
        tx(pr, io, 4'h2, 32'h0001_1fff, ig);
        tx(pr, io, 4'h2, 32'h0001_6000, ig);
        tx(pr, io, 4'h2, 32'h0000_2000, ig);
        tx(se, io, 4'h2, 32'h0001_1fff, up);
        tx(se, io, 4'h3, 32'h0001_2000, ig);
        en_set(4'h2);
        tx(pr, io, 4'h2, 32'h0001_2000, ig);
        en_set(4'h8);
        tx(se, io, 4'h2, 32'h0001_1fff, ig);
        tx(se, me, 4'h7, 32'h8000_0000, ig);
    endtask
    task automatic t_io_off();
        en_set(4'h0);
        cfg_wr(`CFG_OFF_IO_BASE_HIGH, 4'hf, 32'h0001_0002);
        en_set(4'ha);
        chk({31'h0, io_off}, 32'h1);
        tx(pr, io, 4'h2, 32'h0001_3000, ig);
        tx(se, io, 4'h2, 32'h0001_3000, up);
    endtask
    task automatic t_isa();
        en_set(4'h0);
        cfg_wr(`CFG_OFF_IO_BASE_HIGH, 4'hf, 32'h0001_0000);
        cfg_wr(`CFG_OFF_IO_BASE_LOW, 4'h3, 32'h0000_f000);
        en_set(4'hb);
        chk({31'h0, io_off}, 32'h0);
        tx(pr, io, 4'h2, 32'h0000_0400, dn);
        tx(pr, io, 4'h2, 32'h0000_c4ff, dn);
        tx(pr, io, 4'h2, 32'h0000_0500, ig);
        tx(pr, io, 4'h2, 32'h0000_fbff, ig);
        tx(pr, io, 4'h2, 32'h0001_0500, dn);
        tx(se, io, 4'h2, 32'h0000_0600, up);
        tx(se, io, 4'h2, 32'h0000_0400, ig);
        tx(se, io, 4'h2, 32'h0001_0700, ig);
        tx(se, io, 4'h2, 32'h0002_0000, up);
    endtask
    task automatic t_mmio();
        en_set(4'h0);
        cfg_wr(`CFG_OFF_MMIO_BASE, 4'hf, 32'h1fff_100f);
        cfg_rd(`CFG_OFF_MMIO_BASE, 32'h1ff0_1000);
        cfg_rd(8'h24, 32'h0000_0000);
        en_set(4'h6);
        tx(pr, me, `CMD_MEM_READ, 32'h1000_0000, dn_sg);
        tx(pr, me, `CMD_MEM_READ_MULTIPLE, 32'h1fff_fffc, dn_pf);
        tx(pr, me, `CMD_MEM_READ_LINE, 32'h1800_0000, dn_pf);
        tx(pr, me, 4'h7, 32'h0fff_fffc, ig);
        tx(se, me, 4'h6, 32'h1000_0000, ig);
        tx(se, me, 4'h6, 32'h2000_0000, up);
        oc = 1'b1;
        tx(se, me, 4'h6, 32'h2000_0000, ig);
        oc = 1'b0;
        en_set(4'h2);
        tx(pr, me, 4'h6, 32'h1000_0000, ig);
        en_set(4'h0);
        cfg_wr(`CFG_OFF_MMIO_BASE, 4'hf, 32'h2000_3000);
        en_set(4'h6);
        chk({31'h0, mmio_off}, 32'h1);
        tx(pr, me, 4'h6, 32'h2500_0000, ig);
        tx(se, me, 4'h6, 32'h2500_0000, up);
    endtask
    // a second reset in mid-run must restore the default windows
    task automatic t_rerst();
        @(posedge clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        cfg_rd(`CFG_OFF_IO_BASE_HIGH, 32'h0000_0000);
        cfg_rd(`CFG_OFF_MMIO_BASE, 32'h0000_0000);
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        cfg_req = '0;
        en = '0;
        oc = 1'b0;
        err_total = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_io();
        t_io_off();
        t_isa();
        t_mmio();
        t_rerst();
        conclude();
    end

    // a run takes under 150 cycles
    initial begin
        #400000;
        err_total++;
        conclude();
    end
endmodule

`default_nettype wire

/* hw/bridge_decode_cfg.svh */
`ifndef BRIDGE_DECODE_CFG_SVH
`define BRIDGE_DECODE_CFG_SVH

// ----------------------------------------------------------------------------
// configuration space byte offsets
// ----------------------------------------------------------------------------
`define CFG_OFF_IO_BASE_LOW     8'h1c
`define CFG_OFF_IO_LIMIT_LOW    8'h1d
`define CFG_OFF_MMIO_BASE       8'h20
`define CFG_OFF_MMIO_LIMIT      8'h22
`define CFG_OFF_IO_BASE_HIGH    8'h30
`define CFG_OFF_IO_LIMIT_HIGH   8'h32

// ----------------------------------------------------------------------------
// field layout and constant bits
// ----------------------------------------------------------------------------
`define IO_ADDR_CAP_NIBBLE      4'h1
`define IO_BASE_FILL            12'h000
`define IO_LIMIT_FILL           12'hfff
`define MMIO_BASE_FILL          20'h00000
`define MMIO_LIMIT_FILL         20'hfffff
`define MMIO_LOW_NIBBLE         4'h0
`define ISA_UPPER_ZERO          16'h0000
`define ISA_LOW_QUARTER         2'h0

// ----------------------------------------------------------------------------
// reset values of the window fields
// ----------------------------------------------------------------------------
`define RST_IO_NIBBLE           4'h0
`define RST_IO_HIGH             16'h0000
`define RST_MMIO_FIELD          12'h000

// ----------------------------------------------------------------------------
// bus commands that matter to the read policy
// ----------------------------------------------------------------------------
`define CMD_MEM_READ            4'h6
`define CMD_MEM_READ_MULTIPLE   4'hc
`define CMD_MEM_READ_LINE       4'he

`endif

/* hw/bridge_decode_pkg.sv */
`default_nettype none
package bridge_decode_pkg;
    // what the decoder decides for one transaction
    typedef enum logic [1:0] {
        ACT_IGNORE     = 2'h0,
        ACT_DOWNSTREAM = 2'h1,
        ACT_UPSTREAM   = 2'h3
    } decode_action_type;

    typedef enum logic {
        SIDE_PRIMARY   = 1'b0,
        SIDE_SECONDARY = 1'b1
    } bus_side_type;

    typedef enum logic {
        KIND_IO  = 1'b0,
        KIND_MEM = 1'b1
    } txn_kind_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_access_type;

    typedef struct packed {
        logic io_space;
        logic mem_space;
        logic bus_master;
        logic isa;
    } enables_type;

    typedef struct packed {
        logic         valid;
        bus_side_type side;
        txn_kind_type kind;
        logic [3:0]   cmd;
        logic [31:0]  addr;
    } txn_req_type;

    typedef struct packed {
        logic              valid;
        decode_action_type action;
        bus_side_type      side;
        txn_kind_type      kind;
        logic              prefetch;
        logic              single;
        logic [31:0]       addr;
    } decode_result_type;

    typedef struct packed {
        logic [3:0]        io_base_nib;
        logic [3:0]        io_lim_nib;
        logic [15:0]       io_base_hi;
        logic [15:0]       io_lim_hi;
        logic [11:0]       mmio_base;
        logic [11:0]       mmio_lim;
        logic [31:0]       rdata;
        logic              rd_valid;
        logic              io_off;
        logic              mmio_off;
        decode_result_type dec;
    } decoder_state_type;
endpackage
`default_nettype wire

/* hw/bridge_io_mmio_window_decoder.sv */
// What this block does
// - primary i/o inside window goes down, secondary i/o outside goes up
// - i/o enable clear ignores primary i/o
// - master enable clear ignores all secondary traffic
// - i/o base above limit disables window
// - i/o base byte: high nibble bits 15:12
// - upper i/o base word gives bits 31:16
// - i/o base resets to zero
// - i/o limit byte: nibble bits 15:12, fill fff
// - upper i/o limit word gives bits 31:16
// - i/o limit resets to 0000_0fff
// - isa mode acts only in-window below 64k
// - isa: only low 256 bytes go down
// - isa: top 768 bytes go up
// - memory goes down only with memory enable
// - prefetch only for line or multiple reads
// - primary in mmio window down, secondary ignored
// - outside mmio window: primary ignores, secondary up unless other_claim
// - mmio registers map bits 31:20, nibble zero
// - mmio window resets to lowest 1mb
// - mmio base above limit disables window
// - addresses pass unchanged, no unclaimed gaps
`timescale 1ns/1ns
`default_nettype none
`include "bridge_decode_cfg.svh"

module bridge_io_mmio_window_decoder (
    input  wire logic                                 clk,
    input  wire logic                                 sys_rst,
    input  wire bridge_decode_pkg::cfg_access_type    cfg_req,
    output logic [31:0]                               cfg_rdata,
    output logic                                      cfg_rd_valid,
    input  wire bridge_decode_pkg::enables_type       enables,
    input  wire bridge_decode_pkg::txn_req_type       txn,
    input  wire logic                                 other_claim,
    output bridge_decode_pkg::decode_result_type      dec,
    output logic                                      io_window_off,
    output logic                                      mmio_window_off
);

    // ------------------------------------------------------------------------
    // byte offsets of the six fields in the three configuration words
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFF_IO_LOW   = `CFG_OFF_IO_BASE_LOW;
    localparam logic [7:0] OFF_IO_LIMLO = `CFG_OFF_IO_LIMIT_LOW;
    localparam logic [7:0] OFF_MMIO     = `CFG_OFF_MMIO_BASE;
    localparam logic [7:0] OFF_MMIO_LIM = `CFG_OFF_MMIO_LIMIT;
    localparam logic [7:0] OFF_IO_HIGH  = `CFG_OFF_IO_BASE_HIGH;
    localparam logic [7:0] OFF_IO_LIMHI = `CFG_OFF_IO_LIMIT_HIGH;

    // byte lane of each field inside its dword
    localparam logic [1:0] LANE_IO_BASE_LOW  = OFF_IO_LOW[1:0];
    localparam logic [1:0] LANE_IO_LIM_LOW   = OFF_IO_LIMLO[1:0];
    localparam logic [1:0] LANE_MMIO_BASE    = OFF_MMIO[1:0];
    localparam logic [1:0] LANE_MMIO_LIM     = OFF_MMIO_LIM[1:0];
    localparam logic [1:0] LANE_IO_BASE_HIGH = OFF_IO_HIGH[1:0];
    localparam logic [1:0] LANE_IO_LIM_HIGH  = OFF_IO_LIMHI[1:0];

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    bridge_decode_pkg::decoder_state_type state_ff;
    bridge_decode_pkg::decoder_state_type nxt_state;

    // expanded 32-bit window edges
    logic [31:0] io_base_addr;
    logic [31:0] io_limit_addr;
    logic [31:0] mmio_base_addr;
    logic [31:0] mmio_limit_addr;

    // comparator results
    logic        io_hit;
    logic        io_off;
    logic        mmio_hit;
    logic        mmio_off;

    // decode terms
    logic        isa_zone;
    logic        isa_top;
    logic        mem_down;
    logic        rd_prefetch;
    logic        rd_single;

    // word selects per configuration word, shared by writes and read-back
    logic        sel_io_low;
    logic        sel_mmio;
    logic        sel_io_high;
    logic [31:0] lane_mask;

    // ------------------------------------------------------------------------
    // window edges: programmed bits plus the implied fill bits
    // ------------------------------------------------------------------------
    assign io_base_addr    = {state_ff.io_base_hi, state_ff.io_base_nib, `IO_BASE_FILL};
    assign io_limit_addr   = {state_ff.io_lim_hi, state_ff.io_lim_nib, `IO_LIMIT_FILL};
    assign mmio_base_addr  = {state_ff.mmio_base, `MMIO_BASE_FILL};
    assign mmio_limit_addr = {state_ff.mmio_lim, `MMIO_LIMIT_FILL};

    // ------------------------------------------------------------------------
    // window comparators
    // ------------------------------------------------------------------------
    window_match #(
        .AW (32)
    ) u_io_window (
        .addr  (txn.addr),
        .base  (io_base_addr),
        .limit (io_limit_addr),
        .hit   (io_hit),
        .off   (io_off)
    );

    window_match #(
        .AW (32)
    ) u_mmio_window (
        .addr  (txn.addr),
        .base  (mmio_base_addr),
        .limit (mmio_limit_addr),
        .hit   (mmio_hit),
        .off   (mmio_off)
    );

    // ------------------------------------------------------------------------
    // isa aliasing: first 64k, upper three quarters of each 1k block
    // ------------------------------------------------------------------------
    assign isa_zone = (txn.addr[31:16] == `ISA_UPPER_ZERO);
    assign isa_top  = enables.isa && isa_zone &&
                      (txn.addr[9:8] != `ISA_LOW_QUARTER);

    // ------------------------------------------------------------------------
    // read policy on primary memory traffic heading into the mmio window
    // ------------------------------------------------------------------------
    assign mem_down = txn.valid && (txn.kind == bridge_decode_pkg::KIND_MEM) &&
                      (txn.side == bridge_decode_pkg::SIDE_PRIMARY) &&
                      enables.mem_space && mmio_hit;

    read_policy u_read_policy (
        .cmd      (txn.cmd),
        .mem_down (mem_down),
        .prefetch (rd_prefetch),
        .single   (rd_single)
    );

    // ------------------------------------------------------------------------
    // configuration word selects and byte lane mask
    // ------------------------------------------------------------------------
    assign sel_io_low  = (cfg_req.addr[7:2] == OFF_IO_LOW[7:2]);
    assign sel_mmio    = (cfg_req.addr[7:2] == OFF_MMIO[7:2]);
    assign sel_io_high = (cfg_req.addr[7:2] == OFF_IO_HIGH[7:2]);
    assign lane_mask   = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
                          {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

    // ------------------------------------------------------------------------
    // next state: configuration writes, read-back and the decode itself
    // ------------------------------------------------------------------------
    always_comb begin
        logic [31:0] wword;
        logic [31:0] cur;
        bridge_decode_pkg::decode_action_type act;

        wword     = '0;
        cur       = '0;
        act       = bridge_decode_pkg::ACT_IGNORE;
        nxt_state = state_ff;

        // writes; the low nibbles are fixed and never stored
        if (cfg_req.wr) begin
            if (sel_io_low) begin
                cur   = {16'h0000,
                         state_ff.io_lim_nib, `IO_ADDR_CAP_NIBBLE,
                         state_ff.io_base_nib, `IO_ADDR_CAP_NIBBLE};
                wword = (cfg_req.wdata & lane_mask) | (cur & ~lane_mask);
                nxt_state.io_base_nib = wword[8*LANE_IO_BASE_LOW+4 +: 4];
                nxt_state.io_lim_nib  = wword[8*LANE_IO_LIM_LOW+4 +: 4];
            end
            if (sel_mmio) begin
                cur   = {state_ff.mmio_lim, `MMIO_LOW_NIBBLE,
                         state_ff.mmio_base, `MMIO_LOW_NIBBLE};
                wword = (cfg_req.wdata & lane_mask) | (cur & ~lane_mask);
                nxt_state.mmio_base = wword[8*LANE_MMIO_BASE+4 +: 12];
                nxt_state.mmio_lim  = wword[8*LANE_MMIO_LIM+4 +: 12];
            end
            if (sel_io_high) begin
                cur   = {state_ff.io_lim_hi, state_ff.io_base_hi};
                wword = (cfg_req.wdata & lane_mask) | (cur & ~lane_mask);
                nxt_state.io_base_hi = wword[8*LANE_IO_BASE_HIGH +: 16];
                nxt_state.io_lim_hi  = wword[8*LANE_IO_LIM_HIGH +: 16];
            end
        end

        // read-back; words outside this block read as zero
        nxt_state.rd_valid = cfg_req.rd;
        nxt_state.rdata    = '0;
        if (cfg_req.rd) begin
            if (sel_io_low) begin
                nxt_state.rdata = {16'h0000,
                                   state_ff.io_lim_nib, `IO_ADDR_CAP_NIBBLE,
                                   state_ff.io_base_nib, `IO_ADDR_CAP_NIBBLE};
            end else if (sel_mmio) begin
                nxt_state.rdata = {state_ff.mmio_lim, `MMIO_LOW_NIBBLE,
                                   state_ff.mmio_base, `MMIO_LOW_NIBBLE};
            end else if (sel_io_high) begin
                nxt_state.rdata = {state_ff.io_lim_hi, state_ff.io_base_hi};
            end
        end

        // the decode; a change of windows mid-transfer is software's hazard
        if (txn.valid) begin
            unique case ({txn.side, txn.kind})
                {bridge_decode_pkg::SIDE_PRIMARY, bridge_decode_pkg::KIND_IO}: begin
                    // isa holes are kept on the primary side
                    if (enables.io_space && io_hit && !isa_top) begin
                        act = bridge_decode_pkg::ACT_DOWNSTREAM;
                    end
                end
                {bridge_decode_pkg::SIDE_SECONDARY, bridge_decode_pkg::KIND_IO}: begin
                    // isa holes are claimed upward even inside the window
                    if (enables.bus_master && (!io_hit || isa_top)) begin
                        act = bridge_decode_pkg::ACT_UPSTREAM;
                    end
                end
                {bridge_decode_pkg::SIDE_PRIMARY, bridge_decode_pkg::KIND_MEM}: begin
                    if (enables.mem_space && mmio_hit) begin
                        act = bridge_decode_pkg::ACT_DOWNSTREAM;
                    end
                end
                {bridge_decode_pkg::SIDE_SECONDARY, bridge_decode_pkg::KIND_MEM}: begin
                    // the prefetchable range or vga logic may take it downward
                    if (enables.bus_master && !mmio_hit && !other_claim) begin
                        act = bridge_decode_pkg::ACT_UPSTREAM;
                    end
                end
            endcase
        end

        nxt_state.dec.valid    = txn.valid;
        nxt_state.dec.action   = act;
        nxt_state.dec.side     = txn.side;
        nxt_state.dec.kind     = txn.kind;
        nxt_state.dec.prefetch = rd_prefetch;
        nxt_state.dec.single   = rd_single;
        nxt_state.dec.addr     = txn.addr;
        nxt_state.io_off       = io_off;
        nxt_state.mmio_off     = mmio_off;
    end

    // ------------------------------------------------------------------------
    // registers; reset gives the bottom 4k i/o and bottom 1m memory windows
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff             <= '0;
            state_ff.io_base_nib <= `RST_IO_NIBBLE;
            state_ff.io_base_hi  <= `RST_IO_HIGH;
            state_ff.io_lim_nib  <= `RST_IO_NIBBLE;
            state_ff.io_lim_hi   <= `RST_IO_HIGH;
            state_ff.mmio_base   <= `RST_MMIO_FIELD;
            state_ff.mmio_lim    <= `RST_MMIO_FIELD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all taken straight from the state register
    // ------------------------------------------------------------------------
    assign cfg_rdata       = state_ff.rdata;
    assign cfg_rd_valid    = state_ff.rd_valid;
    assign dec             = state_ff.dec;
    assign io_window_off   = state_ff.io_off;
    assign mmio_window_off = state_ff.mmio_off;

endmodule

`default_nettype wire

/* hw/read_policy.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bridge_decode_cfg.svh"

// ----------------------------------------------------------------------------
// read policy for memory transactions sent into the mmio window
// ----------------------------------------------------------------------------
module read_policy (
    input  wire logic [3:0] cmd,
    input  wire logic       mem_down,
    output logic            prefetch,
    output logic            single
);

    // only line and multiple reads may prefetch; a plain read has side
    // effects in this space, so it is held to one data phase
    always_comb begin
        prefetch = 1'b0;
        single   = 1'b0;
        if (mem_down) begin
            prefetch = (cmd == `CMD_MEM_READ_LINE) || (cmd == `CMD_MEM_READ_MULTIPLE);
            single   = (cmd == `CMD_MEM_READ);
        end
    end

endmodule

`default_nettype wire

/* hw/window_match.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// inclusive base..limit comparator, reused for the i/o and mmio windows
// ----------------------------------------------------------------------------
module window_match #(
    parameter int AW = 32
) (
    input  wire logic [AW-1:0] addr,
    input  wire logic [AW-1:0] base,
    input  wire logic [AW-1:0] limit,
    output logic               hit,
    output logic               off
);

    // a base above the limit leaves an empty window, so nothing can hit
    assign off = (base > limit);
    assign hit = !off && (addr >= base) && (addr <= limit);

endmodule

`default_nettype wire
